//--- verilog/alt_mode_cfg.svh
// Offsets, field positions, reset values and instruction codes of the sequencer
`ifndef ALT_MODE_CFG_SVH
`define ALT_MODE_CFG_SVH

`define WORD_W 12
`define FIELD_W 2
`define ADDR_W 10
`define APB_ADDR_W 8

// Register offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_PC 8'h08

// Control bits
`define CTRL_RUN 0
`define CTRL_CONSOLE 1
`define CTRL_SKIP 2
`define CTRL_LINK 3

// Status bits
`define STAT_OVERFLOW 12
`define STAT_SAVE 13
`define STAT_RUN 14
`define STAT_FIELD 16

// Full-address opcodes in instruction bits 00-01
`define FA_ADD 2'h1
`define FA_STC 2'h2
`define FA_JUMP 2'h3

// Index-class opcodes, bits 00-06 with low bits zero
`define OP_LOAD_ACC 12'h200
`define OP_STORE_ACC 12'h220
`define OP_ADD_ACC 12'h240
`define OP_ADD_MEM 12'h260
`define OP_LINK_ADD 12'h280
`define OP_BIT_CLEAR 12'h360
`define OP_BIT_SET 12'h380

// Codes of the field and return controls (arbitrary values)
`define RETURN_DISABLE_CODE 12'h011
`define LOAD_FIELD_CODE 10'h030

`define SAVE_RESET 1'h1

`endif

//--- verilog/alt_mode_pkg.sv
// Types shared by the alternate-mode sequencer
`default_nettype none
`include "alt_mode_cfg.svh"
package alt_mode_pkg;

	typedef enum logic [1:0] {FETCH, DEFER, EXECUTE} major_t;
	typedef enum logic [2:0] {TS1, TS2, TS3, TS4, TS5} tstate_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [`APB_ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_t;

	typedef struct packed {
		logic [`WORD_W-1:0] addr;
		logic [`WORD_W-1:0] wdata;
		logic rd;
		logic wr;
	} mem_req_t;

	typedef struct packed {
		major_t major;
		tstate_t ts;
		logic [`WORD_W-1:0] pc;
		logic [`WORD_W-1:0] ma;
		logic [`WORD_W-1:0] mb;
		logic [`WORD_W-1:0] ir;
		logic [`WORD_W-1:0] acc;
		logic [`FIELD_W-1:0] field;
		logic [`FIELD_W-1:0] fieldBuf;
		logic skip;
		logic saveReturn;
		logic overflow;
		logic consoleCycle;
		logic run;
		logic consoleReq;
		logic link;
		logic [`WORD_W-1:0] lswMeta;
		logic [`WORD_W-1:0] lswSync;
		logic memRd;
		logic memWr;
		apb_rsp_t rsp;
	} state_t;

endpackage
`default_nettype wire

//--- verilog/alt_mode_fetch_execute.sv
// Fetch, defer and execute sequencer for the alternate instruction set
//
// Summary of operation
// - Fetch T1 without console execute loads field and PC into memory address.
// - A set skip flag adds one to the fetch memory address.
// - Fetch T2 increments PC and clears instruction; TP3 loads memory data.
// - Console execute suppresses increments and loads left switches at T3.
// - Full-address ops decode bits 00-01; execute TP1 loads field and address.
// - Full add reads operand at T3 and sums into accumulator at T4.
// - Store-and-clear gates accumulator into buffer at T3, clears it and starts the memory write at T4.
// - Return-disable clears save flag so the next jump leaves 0000 alone.
// - Jump with nonzero target copies field buffer into field at fetch TP4.
// - Jump execute addresses 0000, saves PC plus 6000 if enabled, sets flag.
// - Jump T5 loads PC with target and current field.
// - Index class is bits 0-1 zero, bit 2 one; indirect bit 07, pointer 08-11.
// - Defer follows fetch except indirect with pointer zero, which uses next word.
// - Direct pointer-zero reads address word via PC in defer.
// - Nonzero pointer addresses pointer location, incremented at TP3 when indirect.
// - Load accumulator reads at TP3 and copies buffer to accumulator at TP4.
// - Store accumulator gates accumulator into buffer at TP3 for writing.
// - Add to accumulator reads at TP3 and loads sum at TP4.
// - Add to memory loads sum into buffer and accumulator at TP3, flags overflow.
// - Link add to memory also injects link bit as carry in.
// - Bit clear combines buffer and accumulator logically, loaded at TP4.
// - Bit set loads inclusive OR into accumulator at TP4.
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "alt_mode_cfg.svh"

module alt_mode_fetch_execute
(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire alt_mode_pkg::apb_req_t apbReq,
	output alt_mode_pkg::apb_rsp_t apbRsp,
	input wire logic [`WORD_W-1:0] leftSwitches,
	input wire logic [`WORD_W-1:0] memRdData,
	output alt_mode_pkg::mem_req_t memReq,
	output logic [`WORD_W-1:0] accumulator,
	output logic overflowFlag
);
	import alt_mode_pkg::*;

	state_t s;
	state_t next_s;

	// ************************************************************
	// Decode
	// ************************************************************
	logic isFull;
	logic isIndex;
	logic opAdd;
	logic opStc;
	logic opJump;
	logic indBit;
	logic ptrZero;
	logic directNext;
	logic [`WORD_W-1:0] opCode;
	logic carryIn;
	logic [`WORD_W:0] rdSum;
	logic [`WORD_W-1:0] mbSum;
	logic rdOverflow;
	logic advance;
	logic apbAck;
	logic [31:0] statusWord;

	assign isFull = s.ir[11:10] != 2'h0;
	assign isIndex = s.ir[11:9] == 3'h1;
	assign opAdd = s.ir[11:10] == `FA_ADD;
	assign opStc = s.ir[11:10] == `FA_STC;
	assign opJump = s.ir[11:10] == `FA_JUMP;
	assign indBit = s.ir[4];
	assign ptrZero = s.ir[3:0] == 4'h0;
	assign directNext = indBit && ptrZero;
	assign opCode = {s.ir[11:5], 5'h00};
	assign carryIn = (opCode == `OP_LINK_ADD) && s.link;
	assign rdSum = {1'h0, memRdData} + {1'h0, s.acc} + {12'h000, carryIn};
	assign mbSum = s.mb + s.acc;
	assign rdOverflow = (memRdData[11] == s.acc[11]) && (rdSum[11] != s.acc[11]);
	assign advance = !(s.major == FETCH && s.ts == TS1 && !s.run);
	assign apbAck = apbReq.psel && apbReq.penable && s.rsp.pready;

	always_comb
	begin
		statusWord = 32'h0000_0000;
		statusWord[11:0] = s.acc;
		statusWord[`STAT_OVERFLOW] = s.overflow;
		statusWord[`STAT_SAVE] = s.saveReturn;
		statusWord[`STAT_RUN] = s.run;
		statusWord[`STAT_FIELD+1:`STAT_FIELD] = s.field;
	end

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb
	begin
		next_s = s;
		next_s.memRd = 1'h0;
		next_s.memWr = 1'h0;
		next_s.lswMeta = leftSwitches;
		next_s.lswSync = s.lswMeta;
		next_s.rsp.pready = 1'h0;
		next_s.rsp.pslverr = 1'h0;
		if (apbAck && apbReq.pwrite && apbReq.paddr == `REG_STATUS && apbReq.pwdata[`STAT_OVERFLOW])
		begin
			next_s.overflow = 1'h0;
		end
		if (advance)
		begin
			unique case (s.ts)
				TS1: next_s.ts = TS2;
				TS2: next_s.ts = TS3;
				TS3: next_s.ts = TS4;
				TS4: next_s.ts = TS5;
				TS5: next_s.ts = TS1;
				default: next_s.ts = TS1;
			endcase
			unique case (s.major)
				FETCH:
				begin
					unique case (s.ts)
						TS1:
						begin
							next_s.consoleCycle = s.consoleReq;
							next_s.consoleReq = 1'h0;
							if (!s.consoleReq)
							begin
								next_s.ma = {s.field, s.pc[9:0] + {9'h000, s.skip}};
								next_s.skip = 1'h0;
							end
						end
						TS2:
						begin
							next_s.ir = 12'h000;
							if (!s.consoleCycle)
							begin
								next_s.pc = {s.pc[11:10], s.ma[9:0] + 10'h001};
								next_s.memRd = 1'h1;
							end
						end
						TS3:
						begin
							if (s.consoleCycle)
							begin
								next_s.mb = s.lswSync;
								next_s.ir = s.lswSync;
							end
							else
							begin
								next_s.mb = memRdData;
								next_s.ir = memRdData;
							end
						end
						TS4:
						begin
							if (opJump && s.ir[9:0] != 10'h000)
							begin
								next_s.field = s.fieldBuf;
							end
							if (s.ir == `RETURN_DISABLE_CODE)
							begin
								next_s.saveReturn = 1'h0;
							end
							if (s.ir[11:2] == `LOAD_FIELD_CODE)
							begin
								next_s.fieldBuf = s.ir[1:0];
							end
						end
						TS5:
						begin
							next_s.consoleCycle = 1'h0;
							if (isIndex)
							begin
								next_s.major = directNext ? EXECUTE : DEFER;
							end
							else if (isFull)
							begin
								next_s.major = EXECUTE;
							end
						end
						default:
						begin
						end
					endcase
				end
				DEFER:
				begin
					unique case (s.ts)
						TS1:
						begin
							if (ptrZero)
							begin
								next_s.ma = {s.field, s.pc[9:0]};
							end
							else
							begin
								next_s.ma = {s.field, 6'h00, s.ir[3:0]};
							end
						end
						TS2:
						begin
							next_s.memRd = 1'h1;
							if (ptrZero)
							begin
								next_s.pc = {s.pc[11:10], s.pc[9:0] + 10'h001};
							end
						end
						TS3:
						begin
							next_s.mb = memRdData + {11'h000, indBit && !ptrZero};
						end
						TS4:
						begin
							next_s.memWr = indBit && !ptrZero;
						end
						TS5:
						begin
							next_s.major = EXECUTE;
						end
						default:
						begin
						end
					endcase
				end
				EXECUTE:
				begin
					unique case (s.ts)
						TS1:
						begin
							if (opJump)
							begin
								next_s.ma = {s.field, 10'h000};
							end
							else if (isFull)
							begin
								next_s.ma = {s.field, s.ir[9:0]};
							end
							else if (directNext)
							begin
								next_s.ma = {s.field, s.pc[9:0]};
							end
							else
							begin
								next_s.ma = {s.field, s.mb[9:0]};
							end
						end
						TS2:
						begin
							next_s.memRd = 1'h1;
							if (isIndex && directNext)
							begin
								next_s.pc = {s.pc[11:10], s.pc[9:0] + 10'h001};
							end
						end
						TS3:
						begin
							next_s.mb = memRdData;
							if (opStc)
							begin
								next_s.mb = s.acc;
							end
							else if (opJump && s.saveReturn)
							begin
								next_s.mb = {2'h3, s.pc[9:0]};
							end
							else if (isIndex && opCode == `OP_STORE_ACC)
							begin
								next_s.mb = s.acc;
							end
							else if (isIndex && (opCode == `OP_ADD_MEM || opCode == `OP_LINK_ADD))
							begin
								next_s.mb = rdSum[11:0];
								next_s.acc = rdSum[11:0];
								if (rdOverflow)
								begin
									next_s.overflow = 1'h1;
								end
							end
						end
						TS4:
						begin
							if (opAdd)
							begin
								next_s.acc = mbSum;
							end
							else if (opStc)
							begin
								next_s.acc = 12'h000;
								next_s.memWr = 1'h1;
							end
							else if (opJump)
							begin
								next_s.memWr = s.saveReturn;
								next_s.saveReturn = 1'h1;
							end
							else if (isIndex)
							begin
								unique case (opCode)
									`OP_LOAD_ACC: next_s.acc = s.mb;
									`OP_STORE_ACC: next_s.memWr = 1'h1;
									`OP_ADD_ACC: next_s.acc = mbSum;
									`OP_ADD_MEM: next_s.memWr = 1'h1;
									`OP_LINK_ADD: next_s.memWr = 1'h1;
									`OP_BIT_CLEAR: next_s.acc = s.acc & ~s.mb;
									`OP_BIT_SET: next_s.acc = s.acc | s.mb;
									default:
									begin
									end
								endcase
							end
						end
						TS5:
						begin
							if (opJump)
							begin
								next_s.pc = {s.field, s.ir[9:0]};
							end
							next_s.major = FETCH;
						end
						default:
						begin
						end
					endcase
				end
				default:
				begin
					next_s.major = FETCH;
				end
			endcase
		end
		// ************************************************************
		// APB slave, one wait state
		// ************************************************************
		if (apbReq.psel && apbReq.penable && !s.rsp.pready)
		begin
			next_s.rsp.pready = 1'h1;
			next_s.rsp.prdata = 32'h0000_0000;
			unique case (apbReq.paddr)
				`REG_CTRL: next_s.rsp.prdata[3:0] = {s.link, s.skip, s.consoleReq, s.run};
				`REG_STATUS: next_s.rsp.prdata = statusWord;
				`REG_PC: next_s.rsp.prdata[11:0] = s.pc;
				default: next_s.rsp.pslverr = 1'h1;
			endcase
		end
		if (apbAck && apbReq.pwrite && apbReq.paddr == `REG_CTRL)
		begin
			next_s.run = apbReq.pwdata[`CTRL_RUN];
			next_s.link = apbReq.pwdata[`CTRL_LINK];
			if (apbReq.pwdata[`CTRL_CONSOLE])
			begin
				next_s.consoleReq = 1'h1;
			end
			if (apbReq.pwdata[`CTRL_SKIP])
			begin
				next_s.skip = 1'h1;
			end
		end
		if (apbAck && apbReq.pwrite && apbReq.paddr == `REG_PC && !advance)
		begin
			next_s.pc = apbReq.pwdata[11:0];
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s <= '0;
			s.saveReturn <= `SAVE_RESET;
		end
		else
		begin
			s <= next_s;
		end
	end

	assign apbRsp = s.rsp;
	assign memReq = '{addr: s.ma, wdata: s.mb, rd: s.memRd, wr: s.memWr};
	assign accumulator = s.acc;
	assign overflowFlag = s.overflow;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);

	sequence fetchStart;
		s.major == FETCH && s.ts == TS1 && s.run && !s.consoleReq;
	endsequence

	sequence jumpSave;
		s.major == EXECUTE && s.ts == TS3 && opJump && s.saveReturn;
	endsequence

	a_fetch_address: assert property (fetchStart |=> s.ma == {$past(s.field), $past(s.pc[9:0]) + {9'h000, $past(s.skip)}})
		else $error("fetch address wrong");
	a_pc_increment: assert property (s.major == FETCH && s.ts == TS2 && !s.consoleCycle |=> s.pc[9:0] == $past(s.ma[9:0]) + 10'h001 && s.ir == 12'h000 && memReq.rd ##1 s.ir == $past(memRdData))
		else $error("fetch increment or load wrong");
	a_console_load: assert property (s.major == FETCH && s.ts == TS2 && s.consoleCycle |=> s.pc == $past(s.pc) ##1 s.ir == s.mb && s.ir == $past(s.lswSync))
		else $error("console execute load wrong");
	a_full_add: assert property (s.major == EXECUTE && s.ts == TS3 && opAdd ##1 s.ts == TS4 |=> s.acc == $past(s.mb) + $past(s.acc))
		else $error("full add sum wrong");
	a_store_clear: assert property (s.major == EXECUTE && s.ts == TS3 && opStc |=> s.mb == $past(s.acc) ##1 s.acc == 12'h000 && memReq.wr)
		else $error("store and clear wrong");
	a_jump_save: assert property (jumpSave |=> s.mb == {2'h3, $past(s.pc[9:0])} && s.ma[9:0] == 10'h000 ##1 memReq.wr && s.saveReturn)
		else $error("return save wrong");
	a_return_off: assert property (s.major == EXECUTE && s.ts == TS4 && opJump && !s.saveReturn |=> !memReq.wr && s.saveReturn)
		else $error("disabled return still written");
	a_jump_target: assert property (s.major == EXECUTE && s.ts == TS5 && opJump |=> s.pc == {$past(s.field), $past(s.ir[9:0])} && s.major == FETCH)
		else $error("jump target wrong");
	a_defer_entry: assert property (s.major == FETCH && s.ts == TS5 && isIndex |=> s.major == ($past(directNext) ? EXECUTE : DEFER))
		else $error("defer entry wrong");
	a_pointer_bump: assert property (s.major == DEFER && s.ts == TS3 && indBit && !ptrZero |=> s.mb == $past(memRdData) + 12'h001 ##1 memReq.wr)
		else $error("pointer increment wrong");
	a_bit_set: assert property (s.major == EXECUTE && s.ts == TS4 && isIndex && opCode == `OP_BIT_SET |=> s.acc == ($past(s.acc) | $past(s.mb)))
		else $error("bit set wrong");

endmodule
`default_nettype wire

//--- dv/core_memory_model.sv
// Behavioural core memory on the far side of the sequencer
`timescale 1ns/10ps
`default_nettype none
`include "alt_mode_cfg.svh"
module core_memory_model
(
	input wire logic ref_clk,
	input wire alt_mode_pkg::mem_req_t memReq,
	output logic [`WORD_W-1:0] memRdData
);
	import alt_mode_pkg::*;
	// ****************************************
	// Storage and read path
	// ****************************************
	logic [`WORD_W-1:0] mem [0:4095];
	logic [`WORD_W-1:0] lastData = '0;
	// Data only while the read strobe stands, scrambled otherwise
	always_comb
	begin
		if (memReq.rd)
			memRdData = mem[memReq.addr];
		else
			memRdData = ~lastData;
	end
	always @(posedge ref_clk)
	begin
		if (memReq.rd)
			lastData <= mem[memReq.addr];
		if (memReq.wr)
			mem[memReq.addr] <= memReq.wdata;
	end
endmodule
`default_nettype wire

//--- dv/alt_mode_fetch_execute_bench.sv
// Self-checking bench of the alternate-mode sequencer
`timescale 1ns/10ps
`default_nettype none
`include "alt_mode_cfg.svh"
module alt_mode_fetch_execute_bench;
	import alt_mode_pkg::*;
	typedef struct {
		logic [11:0] instr;
		logic [11:0] accIn;
		logic [11:0] memIn;
		logic link;
		logic [11:0] accExp;
		logic [11:0] memExp;
		logic ovExp;
	} row_t;
	logic ref_clk;
	logic arst_n;
	apb_req_t apbReq;
	apb_rsp_t apbRsp;
	logic [11:0] leftSwitches;
	logic [11:0] memRdData;
	mem_req_t memReq;
	logic [11:0] accumulator;
	logic overflowFlag;
	int numErrors = 0;
	int comparisons = 0;
	row_t rows [10] = '{
		'{12'h500, 12'h123, 12'h111, 1'b0, 12'h234, 12'h111, 1'b0},
		'{12'h900, 12'h5A5, 12'h777, 1'b0, 12'h000, 12'h5A5, 1'b0},
		'{12'h200, 12'h001, 12'h3C3, 1'b0, 12'h3C3, 12'h3C3, 1'b0},
		'{12'h222, 12'h456, 12'h000, 1'b0, 12'h456, 12'h456, 1'b0},
		'{12'h251, 12'h00F, 12'h011, 1'b0, 12'h020, 12'h011, 1'b0},
		'{12'h262, 12'h7FF, 12'h001, 1'b0, 12'h800, 12'h800, 1'b1},
		'{12'h282, 12'h010, 12'h005, 1'b1, 12'h016, 12'h016, 1'b0},
		'{12'h362, 12'h0FF, 12'h00F, 1'b0, 12'h0F0, 12'h00F, 1'b0},
		'{12'h382, 12'h0F0, 12'h00F, 1'b0, 12'h0FF, 12'h00F, 1'b0},
		'{12'h210, 12'h777, 12'h3C3, 1'b0, 12'h100, 12'h3C3, 1'b0}
	};

	alt_mode_fetch_execute u_alt_mode_fetch_execute
	(
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.apbReq(apbReq),
		.apbRsp(apbRsp),
		.leftSwitches(leftSwitches),
		.memRdData(memRdData),
		.memReq(memReq),
		.accumulator(accumulator),
		.overflowFlag(overflowFlag)
	);
	core_memory_model u_core_memory_model
	(
		.ref_clk(ref_clk),
		.memReq(memReq),
		.memRdData(memRdData)
	);

	// ****************************************
	// Clock, watchdog and tasks
	// ****************************************
	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		numErrors++;
		giveVerdict();
	end
	task automatic giveVerdict();
		if (numErrors == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic check12(input logic [11:0] got, input logic [11:0] exp, input string what);
		comparisons++;
		if (got !== exp)
		begin
			numErrors++;
			$display("BAD %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
		output logic [31:0] rdata, output logic err);
		int n;
		n = 0;
		apbReq <= '{1'b1, 1'b0, wr, addr, wdata};
		@(posedge ref_clk);
		apbReq.penable <= 1'b1;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (apbRsp.pready !== 1'b1 && n < 50);
		if (n == 50)
			numErrors++;
		rdata = apbRsp.prdata;
		err = apbRsp.pslverr;
		apbReq <= '0;
		@(posedge ref_clk);
	endtask
	task automatic rdCheck(input logic [7:0] addr, input logic [31:0] exp, input logic expErr);
		logic [31:0] d;
		logic e;
		apb(1'b0, addr, 32'h0000_0000, d, e);
		comparisons++;
		if (d !== exp || e !== expErr)
		begin
			numErrors++;
			$display("BAD %0t read %h got %h want %h", $time, addr, d, exp);
		end
	endtask
	task automatic wrReg(input logic [7:0] addr, input logic [31:0] data);
		logic [31:0] d;
		logic e;
		apb(1'b1, addr, data, d, e);
	endtask
	// One instruction: run, then stop at the next fetch
	task automatic step(input logic [3:0] bits);
		wrReg(`REG_CTRL, {28'h000_0000, bits | 4'h1});
		wrReg(`REG_CTRL, {28'h000_0000, bits & 4'h8});
		repeat (20) @(posedge ref_clk);
	endtask
	task automatic poke(input logic [11:0] a, input logic [11:0] d);
		u_core_memory_model.mem[a] = d;
	endtask

	// ****************************************
	// Test sequence
	// ****************************************
	initial
	begin
		arst_n = 1'b0;
		apbReq = '0;
		leftSwitches = 12'h500;
		repeat (5) @(posedge ref_clk);
		arst_n <= 1'b1;
		@(posedge ref_clk);
		foreach (rows[i])
		begin
			poke(12'h040, 12'h210);
			poke(12'h041, rows[i].accIn);
			poke(12'h042, rows[i].instr);
			poke(12'h043, 12'h100);
			poke(12'h001, 12'h0FF);
			poke(12'h002, 12'h100);
			poke(12'h100, rows[i].memIn);
			wrReg(`REG_STATUS, 32'h0000_1000);
			wrReg(`REG_PC, 32'h0000_0040);
			step(4'h0);
			step({rows[i].link, 3'h0});
			check12(accumulator, rows[i].accExp, "acc");
			check12(u_core_memory_model.mem[12'h100], rows[i].memExp, "operand");
			check12(u_core_memory_model.mem[12'h001], (rows[i].instr[4:0] == 5'h11) ? 12'h100 : 12'h0FF,
				"pointer");
			check12({11'h000, overflowFlag}, {11'h000, rows[i].ovExp}, "overflow");
		end
		poke(12'h040, 12'hC80);
		wrReg(`REG_PC, 32'h0000_0040);
		step(4'h0);
		rdCheck(`REG_PC, 32'h0000_0080, 1'b0);
		check12(u_core_memory_model.mem[12'h000], 12'hC41, "return word");
		poke(12'h080, `RETURN_DISABLE_CODE);
		poke(12'h081, 12'hC00);
		poke(12'h000, 12'h555);
		step(4'h0);
		rdCheck(`REG_STATUS, 32'h0000_0100, 1'b0);
		step(4'h0);
		check12(u_core_memory_model.mem[12'h000], 12'h555, "kept word");
		rdCheck(`REG_STATUS, 32'h0000_2100, 1'b0);
		rdCheck(`REG_PC, 32'h0000_0000, 1'b0);
		poke(12'h040, 12'h900);
		poke(12'h041, 12'h210);
		poke(12'h042, 12'h3AB);
		wrReg(`REG_PC, 32'h0000_0040);
		step(4'h4);
		check12(accumulator, 12'h3AB, "skip acc");
		rdCheck(`REG_PC, 32'h0000_0043, 1'b0);
		poke(12'h100, 12'h001);
		wrReg(`REG_PC, 32'h0000_0040);
		step(4'h2);
		check12(accumulator, 12'h3AC, "console acc");
		rdCheck(`REG_PC, 32'h0000_0040, 1'b0);
		poke(12'h040, {`LOAD_FIELD_CODE, 2'h1});
		poke(12'h041, 12'hC80);
		step(4'h0);
		step(4'h0);
		rdCheck(`REG_STATUS, 32'h0001_23AC, 1'b0);
		rdCheck(`REG_PC, 32'h0000_0480, 1'b0);
		poke(12'h480, 12'h210);
		poke(12'h481, 12'h0AA);
		step(4'h0);
		check12(accumulator, 12'h0AA, "field fetch");
		arst_n <= 1'b0;
		repeat (5) @(posedge ref_clk);
		arst_n <= 1'b1;
		@(posedge ref_clk);
		check12(accumulator, 12'h000, "reset acc");
		rdCheck(`REG_STATUS, 32'h0000_2000, 1'b0);
		rdCheck(`REG_CTRL, 32'h0000_0000, 1'b0);
		rdCheck(8'h0C, 32'h0000_0000, 1'b1);
		giveVerdict();
	end
endmodule
`default_nettype wire
